// file: core/pin_sync.sv
/*
 * two-flop synchroniser for a bus of independent levels.
 * assumes each bit is a slow level with no relation to its neighbours.
 */
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    // ****************************************************
    // two stages, first read only by the second
    // ****************************************************
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// file: core/usb_serial_pkg.sv
/*
 * constants, types and helpers for the transceiver serial port.
 * assumes a single 100 MHz mclk domain and an external full-speed
 * transceiver wired in one of four modes chosen before traffic starts.
 */
// What this block does
// - four wiring modes, shared or separate pins
// - active-low transmit enable, low means transmitting
// - shared data pin: drive tx, else receive
// - shared zero pin: drive request, else indication
// - separate data/zero mode: pins are outputs only
// - shared plus/minus pins: drive tx, else receive
// - separate plus/minus: drive outputs, read inputs
package usb_serial_pkg;

    // ****************************************************
    // wiring modes
    // ****************************************************
    typedef enum logic [1:0] {
        data_and_zero_encoding_shared,
        data_and_zero_encoding_separate,
        plus_minus_level_encoding_shared,
        plus_minus_level_encoding_separate
    } wire_mode_t;

    // ****************************************************
    // constants
    // ****************************************************
    localparam wire_mode_t MODE_RESET  = data_and_zero_encoding_shared;
    localparam int         SYNC_STAGES = 2;
    localparam int         MCLK_NS     = 10;
    // pin disable delay is at most 10 ns; the wait also covers the
    // synchroniser so stale own-drive never reaches the receive side
    localparam int         DISABLE_NS  = 10;
    localparam int         TURN_CYCLES =
        (DISABLE_NS + MCLK_NS - 1) / MCLK_NS + SYNC_STAGES;
    localparam logic [1:0] TURN_RESET  = 2'(TURN_CYCLES);

    // ****************************************************
    // carriers
    // ****************************************************
    typedef struct packed {
        logic dp;
        logic dm;
    } line_t;

    typedef struct packed {
        logic dat_pin;
        logic zero_pin;
        logic plus_in;
        logic minus_in;
        logic diff_in;
    } rx_pins_t;

    typedef struct packed {
        logic rcv;
        logic dp;
        logic dm;
    } rx_line_t;

    typedef struct packed {
        wire_mode_t mode;
        logic       txoe_n;
        logic       plus_o;
        logic       zero_o;
        logic       plus_oe_n;
        logic       zero_oe_n;
        logic [1:0] turn;
        logic       rx_valid;
        rx_line_t   rx;
    } port_state_t;

    // ****************************************************
    // helpers
    // ****************************************************
    function automatic logic is_shared(input wire_mode_t m);
        return (m == data_and_zero_encoding_shared) ||
               (m == plus_minus_level_encoding_shared);
    endfunction

    function automatic logic is_data_and_zero_encoding(input wire_mode_t m);
        return (m == data_and_zero_encoding_shared) ||
               (m == data_and_zero_encoding_separate);
    endfunction

endpackage

// file: core/usb_transceiver_serial_port.sv
/*
 * digital side of the serial link to an external full-speed usb
 * transceiver: drives the active-low transmit enable, encodes the
 * line state onto the shared or output-only pins, and decodes the
 * receive pins into one line-state view for every wiring mode.
 * assumes the link layer supplies line levels at the bit rate on mclk
 * and that the mode input is settled before traffic starts.
 */
`timescale 1ns/100ps
module usb_transceiver_serial_port (
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    input  wire usb_serial_pkg::wire_mode_t mode_sel,
    input  wire logic                       tx_req,
    input  wire usb_serial_pkg::line_t      tx_line,
    output logic                            tx_drive_enable_n,
    output logic                            line_data_plus_pin_o,
    output logic                            line_data_plus_pin_oe_n,
    input  wire logic                       line_data_plus_pin_i,
    output logic                            line_zero_minus_pin_o,
    output logic                            line_zero_minus_pin_oe_n,
    input  wire logic                       line_zero_minus_pin_i,
    input  wire logic                       rx_plus_level_in,
    input  wire logic                       rx_minus_level_in,
    input  wire logic                       rx_differential_in,
    output usb_serial_pkg::wire_mode_t      mode_active,
    output logic                            rx_valid,
    output usb_serial_pkg::rx_line_t        rx_line
);

    // ****************************************************
    // pin synchronisers
    // ****************************************************
    usb_serial_pkg::rx_pins_t pins_raw;
    usb_serial_pkg::rx_pins_t pins_s;

    assign pins_raw = '{dat_pin:  line_data_plus_pin_i,
                        zero_pin: line_zero_minus_pin_i,
                        plus_in:  rx_plus_level_in,
                        minus_in: rx_minus_level_in,
                        diff_in:  rx_differential_in};

    pin_sync #(
        .WIDTH ($bits(usb_serial_pkg::rx_pins_t))
    ) i_pin_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     (pins_raw),
        .q     (pins_s)
    );

    // ****************************************************
    // receive decode per mode
    // ****************************************************
    function automatic usb_serial_pkg::rx_line_t decode_rx(
        input usb_serial_pkg::wire_mode_t m,
        input usb_serial_pkg::rx_pins_t   p
    );
        usb_serial_pkg::rx_line_t r;
        r = '0;
        case (m)
            usb_serial_pkg::data_and_zero_encoding_shared: begin
                r.rcv = p.dat_pin;
                r.dp  = !p.zero_pin && p.dat_pin;
                r.dm  = !p.zero_pin && !p.dat_pin;
            end
            usb_serial_pkg::data_and_zero_encoding_separate: begin
                r = '{rcv: p.diff_in, dp: p.plus_in,
                      dm: p.minus_in};
            end
            usb_serial_pkg::plus_minus_level_encoding_shared: begin
                r = '{rcv: p.diff_in, dp: p.dat_pin,
                      dm: p.zero_pin};
            end
            usb_serial_pkg::plus_minus_level_encoding_separate: begin
                r = '{rcv: p.diff_in, dp: p.plus_in,
                      dm: p.minus_in};
            end
            default: begin
                r = '0;
            end
        endcase
        return r;
    endfunction

    // ****************************************************
    // state
    // ****************************************************
    usb_serial_pkg::port_state_t st_q;
    usb_serial_pkg::port_state_t st_d;

    always_comb begin
        st_d = st_q;
        // mode changes only while idle and not requested
        if (st_q.txoe_n && !tx_req) begin
            st_d.mode = mode_sel;
        end
        st_d.txoe_n = !tx_req;
        if (tx_req) begin
            if (usb_serial_pkg::is_data_and_zero_encoding(st_q.mode)) begin
                st_d.plus_o = tx_line.dp;
                st_d.zero_o = !tx_line.dp && !tx_line.dm;
            end else begin
                st_d.plus_o = tx_line.dp;
                st_d.zero_o = tx_line.dm;
            end
        end
        // next mode, so a switch to shared releases at once
        if (usb_serial_pkg::is_shared(st_d.mode)) begin
            st_d.plus_oe_n = !tx_req;
            st_d.zero_oe_n = !tx_req;
        end else begin
            st_d.plus_oe_n = 1'b0;
            st_d.zero_oe_n = 1'b0;
        end
        // receive turnaround after the drivers let go
        if (tx_req || !st_q.txoe_n) begin
            st_d.turn     = usb_serial_pkg::TURN_RESET;
            st_d.rx_valid = 1'b0;
        end else if (st_q.turn != 2'h0) begin
            st_d.turn     = st_q.turn - 2'h1;
            st_d.rx_valid = 1'b0;
        end else begin
            st_d.rx_valid = 1'b1;
            st_d.rx       = decode_rx(st_q.mode, pins_s);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q           <= '0;
            st_q.mode      <= usb_serial_pkg::MODE_RESET;
            st_q.txoe_n    <= 1'b1;
            st_q.plus_oe_n <= 1'b1;
            st_q.zero_oe_n <= 1'b1;
            st_q.turn      <= usb_serial_pkg::TURN_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign tx_drive_enable_n        = st_q.txoe_n;
    assign line_data_plus_pin_o     = st_q.plus_o;
    assign line_data_plus_pin_oe_n  = st_q.plus_oe_n;
    assign line_zero_minus_pin_o    = st_q.zero_o;
    assign line_zero_minus_pin_oe_n = st_q.zero_oe_n;
    assign mode_active              = st_q.mode;
    assign rx_valid                 = st_q.rx_valid;
    assign rx_line                  = st_q.rx;

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_mode_take: assert property (
        (tx_drive_enable_n && !tx_req)
        |=> (mode_active == $past(mode_sel)))
        else $error("mode not taken while idle");

    a_enable_drop: assert property (
        !tx_req |=> tx_drive_enable_n)
        else $error("enable held low without request");

    a_enable_follow: assert property (
        $rose(tx_req) |=> !tx_drive_enable_n [*1] ##0
            $stable(mode_active))
        else $error("enable did not follow request");

    a_shared_release: assert property (
        (tx_drive_enable_n && usb_serial_pkg::is_shared(mode_active))
        |-> (line_data_plus_pin_oe_n && line_zero_minus_pin_oe_n))
        else $error("shared pins driven while receiving");

    a_shared_drive: assert property (
        (!tx_drive_enable_n && usb_serial_pkg::is_shared(mode_active))
        |-> (!line_data_plus_pin_oe_n && !line_zero_minus_pin_oe_n))
        else $error("shared pins not driven while sending");

    a_separate_out: assert property (
        (!usb_serial_pkg::is_shared(mode_active) &&
         $stable(mode_active))
        |-> (!line_data_plus_pin_oe_n && !line_zero_minus_pin_oe_n))
        else $error("output-only pins released");

    a_zero_encode: assert property (
        (tx_req && usb_serial_pkg::is_data_and_zero_encoding(mode_active))
        |=> (line_zero_minus_pin_o ==
             (!$past(tx_line.dp) && !$past(tx_line.dm))))
        else $error("zero request wrongly encoded");

    a_tx_data: assert property (
        tx_req |=> (line_data_plus_pin_o == $past(tx_line.dp)))
        else $error("data pin does not carry transmit level");

    a_level_encode: assert property (
        (tx_req && !usb_serial_pkg::is_data_and_zero_encoding(mode_active))
        |=> (line_data_plus_pin_o == $past(tx_line.dp) &&
             line_zero_minus_pin_o == $past(tx_line.dm)))
        else $error("plus/minus levels wrongly encoded");

    a_mode_hold: assert property (
        !tx_drive_enable_n |=> $stable(mode_active))
        else $error("mode changed during transmit");

    a_rx_turn: assert property (
        $rose(tx_drive_enable_n) |-> !rx_valid [*4])
        else $error("receive view shown during turnaround");

    a_rx_ready: assert property (
        (tx_drive_enable_n && !tx_req) [*4] |=> rx_valid)
        else $error("receive view late after turnaround");

    a_rx_hold: assert property (
        !tx_drive_enable_n |=> $stable(rx_line) && !rx_valid)
        else $error("receive view moved during transmit");

endmodule

// file: sim/usb_transceiver_serial_port_tb.sv
/*
 * self-checking bench for the transceiver serial port.
 * assumes the transceiver model and the design files are compiled.
 */
`timescale 1ns/100ps
module usb_transceiver_serial_port_tb;
    logic                       mclk     = 1'b0;
    logic                       rst_n    = 1'b0;
    usb_serial_pkg::wire_mode_t mode_sel = usb_serial_pkg::MODE_RESET;
    logic                       tx_req   = 1'b0;
    usb_serial_pkg::line_t      tx_line  = 2'h0;
    logic                       bus_dp   = 1'b1;
    logic                       bus_dm   = 1'b0;
    logic                       en_n, dat_o, dat_oe_n, zero_o, zero_oe_n;
    logic                       dat_w, zero_w, plus_w, minus_w, diff_w;
    logic                       rx_valid;
    usb_serial_pkg::wire_mode_t mode_active;
    usb_serial_pkg::rx_line_t   rx_line;
    int                         error_cnt = 0;
    int                         tests_run = 0;

    always #5 mclk = ~mclk;

    usb_transceiver_serial_port i_usb_transceiver_serial_port (
        .mclk(mclk), .rst_n(rst_n), .mode_sel(mode_sel),
        .tx_req(tx_req), .tx_line(tx_line), .tx_drive_enable_n(en_n),
        .line_data_plus_pin_o(dat_o), .line_data_plus_pin_oe_n(dat_oe_n),
        .line_data_plus_pin_i(dat_w), .line_zero_minus_pin_o(zero_o),
        .line_zero_minus_pin_oe_n(zero_oe_n),
        .line_zero_minus_pin_i(zero_w), .rx_plus_level_in(plus_w),
        .rx_minus_level_in(minus_w), .rx_differential_in(diff_w),
        .mode_active(mode_active), .rx_valid(rx_valid),
        .rx_line(rx_line));

    usb_xcvr_model i_usb_xcvr_model (
        .mode(mode_active), .bus_dp(bus_dp), .bus_dm(bus_dm),
        .drive_en_n(en_n), .dat_o(dat_o), .dat_oe_n(dat_oe_n),
        .zero_o(zero_o), .zero_oe_n(zero_oe_n), .dat_wire(dat_w),
        .zero_wire(zero_w), .plus_in(plus_w), .minus_in(minus_w),
        .diff_in(diff_w));

    // ****************************************************
    // scenarios
    // ****************************************************
    task automatic check(input string what, input logic [3:0] exp, got);
        tests_run++;
        if (exp !== got) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic t_reset;
        check("enable_n", 4'h1, 4'(en_n));
        check("oe_n", 4'h3, 4'({dat_oe_n, zero_oe_n}));
        check("rx_valid", 4'h0, 4'(rx_valid));
        check("mode", 4'(usb_serial_pkg::MODE_RESET), 4'(mode_active));
    endtask

    task automatic t_mode(input logic [1:0] m);
        mode_sel = usb_serial_pkg::wire_mode_t'(m);
        @(negedge mclk);
        check("mode", 4'(m), 4'(mode_active));
    endtask

    // J, K, zero, J back to back; mode change tried mid-frame
    task automatic t_tx(input logic [1:0] m);
        logic [1:0] seq [4];
        logic       zx;
        seq = '{2'h2, 2'h1, 2'h0, 2'h2};
        tx_req = 1'b1;
        tx_line = seq[0];
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk);
            zx = m[1] ? seq[i][0] : (seq[i] == 2'h0);
            check("enable_n", 4'h0, 4'(en_n));
            check("dat_o", 4'(seq[i][1]), 4'(dat_o));
            check("zero_o", 4'(zx), 4'(zero_o));
            check("tx oe_n", 4'h0, 4'({dat_oe_n, zero_oe_n}));
            if (i == 1) mode_sel = usb_serial_pkg::wire_mode_t'(~m);
            if (i < 3) tx_line = seq[i+1];
            else tx_req = 1'b0;
        end
        mode_sel = usb_serial_pkg::wire_mode_t'(m);
        @(negedge mclk);
        check("enable_n", 4'h1, 4'(en_n));
        check("rx oe_n", m[0] ? 4'h0 : 4'h3,
              4'({dat_oe_n, zero_oe_n}));
        check("turn rx_valid", 4'h0, 4'(rx_valid));
        check("mode lock", 4'(m), 4'(mode_active));
    endtask

    // J, K and zero received; the first waits out the turnaround
    task automatic t_rx(input logic [1:0] m);
        logic [1:0] seq [3];
        seq = '{2'h2, 2'h1, 2'h0};
        for (int i = 0; i < 3; i++) begin
            {bus_dp, bus_dm} = seq[i];
            repeat (3) begin
                @(negedge mclk);
                if (i == 0) check("turn rx_valid", 4'h0, 4'(rx_valid));
            end
            if (i == 0) @(negedge mclk);
            check("rx_valid", 4'h1, 4'(rx_valid));
            check("rx_line", {1'b0, bus_dp, bus_dp, bus_dm},
                  4'(rx_line));
        end
        {bus_dp, bus_dm} = 2'h2;
        check("mode", 4'(m), 4'(mode_active));
    endtask

    // ****************************************************
    // sequence and watchdog
    // ****************************************************
    initial begin
        repeat (10) @(negedge mclk);
        t_reset();
        rst_n = 1'b1;
        for (int m = 0; m < 4; m++) begin
            t_mode(2'(m));
            t_tx(2'(m));
            t_rx(2'(m));
        end
        stop_test();
    end

    initial begin
        #20000;
        error_cnt++;
        $display("[ERR] watchdog expected done seen timeout");
        stop_test();
    end
endmodule

// file: sim/usb_xcvr_model.sv
/*
 * behavioural full-speed transceiver on the far side of the port.
 * assumes the bench supplies the bus state and the wiring mode.
 */
`timescale 1ns/100ps
module usb_xcvr_model (
    input  wire usb_serial_pkg::wire_mode_t mode,
    input  wire logic                       bus_dp,
    input  wire logic                       bus_dm,
    input  wire logic                       drive_en_n,
    input  wire logic                       dat_o,
    input  wire logic                       dat_oe_n,
    input  wire logic                       zero_o,
    input  wire logic                       zero_oe_n,
    output logic                            dat_wire,
    output logic                            zero_wire,
    output logic                            plus_in,
    output logic                            minus_in,
    output logic                            diff_in
);
    // ****************************************************
    // pin levels
    // ****************************************************
    logic [1:0] mv;
    logic       dz;
    logic       shr;
    logic       rx_on;
    logic       zero_v;

    // mode code: bit 1 plus/minus, bit 0 separate pins
    always_comb begin
        mv     = 2'(mode);
        dz     = !mv[1];
        shr    = !mv[0];
        rx_on  = drive_en_n;
        zero_v = dz ? (!bus_dp && !bus_dm) : bus_dm;
        // both parties driving a shared pin resolves unknown
        if (!dat_oe_n && rx_on && shr) dat_wire = 1'bx;
        else if (!dat_oe_n) dat_wire = dat_o;
        else if (rx_on && shr) dat_wire = bus_dp;
        else dat_wire = ~dat_o;
        if (!zero_oe_n && rx_on && shr) zero_wire = 1'bx;
        else if (!zero_oe_n) zero_wire = zero_o;
        else if (rx_on && shr) zero_wire = zero_v;
        else zero_wire = ~zero_o;
        plus_in  = (rx_on && !shr) ? bus_dp : ~bus_dp;
        minus_in = (rx_on && !shr) ? bus_dm : ~bus_dm;
        diff_in  = (!dz || rx_on) ? bus_dp : ~bus_dp;
    end
endmodule
